/* include/pssw_regs.svh */
// Purpose: Constants for the power switch serial control slave
// Assumes: 40 MHz system clock, serial clock of at most 5 MHz
// Notes: Command and field layout of the 8-bit frame are placed here
//
// Overview of operation
// - Full-duplex slave on four serial lines
// - Access opens on select fall, closes on rise
// - Sample input on clock fall, launch on rise
// - Reset and sleep command restore register defaults
// - Select high: ignore clock, input; output floats
// - Select fall loads diagnosis into shift register
// - Select rise after whole bytes copies shift register into matrix, except a sleep command, which clears it
// - Select rise ending a whole-byte access clears diagnosis flags
// - Only valid commands are executed
// - Eight-bit frame, MSB first, command then data
// - Output floats until select low, MSB first
// - Current sense only when programmed, selected channel
// - Programmable option senses summed channel current
// - Daisy chain: shifted-in bits pass to output
// - Diagnosis latched, cleared after successful transfer
`ifndef PSSW_REGS_SVH
`define PSSW_REGS_SVH

// ==========================================================
// Frame layout
`define PSSW_FRAME_BITS 8
`define PSSW_CMD_MSB 7
`define PSSW_CMD_LSB 4
`define PSSW_DATA_MSB 3
`define PSSW_DATA_LSB 0

// ==========================================================
// Data field positions
`define PSSW_CH0_BIT 0
`define PSSW_CH1_BIT 1
`define PSSW_SENSE_EN_BIT 0
`define PSSW_SENSE_SEL_BIT 1
`define PSSW_SENSE_SUM_BIT 2

// ==========================================================
// Reset values
`define PSSW_CHANNEL_RST 2'h0
`define PSSW_MATRIX_RST 8'h00
`define PSSW_DIAG_RST 8'h00

`endif

/* include/pssw_pkg.sv */
// Purpose: Types for the power switch serial control slave
// Assumes: Included constants live in pssw_regs.svh
// Notes: Command codes are four bits wide
package pssw_pkg;

  // ==========================================================
  // Frame tracking state
  typedef enum logic [0:0] {
    PSSW_ST_IDLE = 1'b0,
    PSSW_ST_FRAME = 1'b1
  } pssw_state_t;

  // ==========================================================
  // Command codes
  typedef enum logic [3:0] {
    PSSW_CMD_NOP = 4'h0,
    PSSW_CMD_CHANNEL = 4'h1,
    PSSW_CMD_SENSE = 4'h2,
    PSSW_CMD_SLEEP = 4'h3,
    PSSW_CMD_WAKE = 4'h4
  } pssw_cmd_t;

endpackage

/* rtl/pssw_spi_slave.sv */
// Purpose: Serial control and diagnosis slave of a dual-channel power switch
// Assumes: Serial pins are asynchronous to clk_in and sampled twice
// Notes: Serial clock must stay below one fifth of clk_in
`timescale 1ns/1ps
`include "pssw_regs.svh"

module pssw_spi_slave
  import pssw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_n_out,
  input wire logic [7:0] fault_in,
  output logic [7:0] diag_out,
  output logic [7:0] matrix_out,
  output logic [1:0] channel_on_out,
  output logic sleep_out,
  output logic current_sense_enable_out,
  output logic current_sense_channel_out,
  output logic current_sense_sum_out,
  output logic frame_error_out
);

  // ==========================================================
  // Pin synchronisers
  logic cs_s1_reg, cs_s2_reg, cs_d_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
  logic si_s1_reg, si_s2_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_d_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      si_s1_reg <= 1'b0;
      si_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_d_reg <= cs_s2_reg;
      sclk_s1_reg <= sclk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      si_s1_reg <= si_in;
      si_s2_reg <= si_s1_reg;
    end
  end

  // ==========================================================
  // Edge events
  // Clock edges count only while selected; the master keeps clock low at select edges
  logic cs_fall, cs_rise, sclk_fall, sclk_rise;
  assign cs_fall = cs_d_reg & ~cs_s2_reg;
  assign cs_rise = ~cs_d_reg & cs_s2_reg;
  assign sclk_fall = sclk_d_reg & ~sclk_s2_reg & ~cs_s2_reg & ~cs_d_reg;
  assign sclk_rise = ~sclk_d_reg & sclk_s2_reg & ~cs_s2_reg & ~cs_d_reg;

  // ==========================================================
  // Frame tracking
  pssw_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic got_byte_reg;
  logic frame_ok;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= PSSW_ST_IDLE;
    end else begin
      case (state_reg)
        PSSW_ST_IDLE: begin
          if (cs_fall) begin
            state_reg <= PSSW_ST_FRAME;
          end
        end
        PSSW_ST_FRAME: begin
          if (cs_rise) begin
            state_reg <= PSSW_ST_IDLE;
          end
        end
        default: begin
          state_reg <= PSSW_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_reg <= 3'h0;
      got_byte_reg <= 1'b0;
    end else if (cs_fall) begin
      bit_cnt_reg <= 3'h0;
      got_byte_reg <= 1'b0;
    end else if (sclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (bit_cnt_reg == 3'h7) begin
        got_byte_reg <= 1'b1;
      end
    end
  end

  // Whole bytes only; a chain may carry several, the last eight received are ours
  assign frame_ok = (state_reg == PSSW_ST_FRAME) && (bit_cnt_reg == 3'h0) && got_byte_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_error_out <= 1'b0;
    end else if (cs_rise) begin
      frame_error_out <= ~frame_ok;
    end
  end

  // ==========================================================
  // Shift register and serial output
  logic [7:0] shift_reg;
  logic [7:0] diag_reg;
  logic so_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg <= `PSSW_DIAG_RST;
    end else if (cs_fall) begin
      shift_reg <= diag_reg;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[6:0], si_s2_reg};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      so_reg <= 1'b0;
    end else if (cs_fall) begin
      so_reg <= diag_reg[7];
    end else if (sclk_rise) begin
      so_reg <= shift_reg[7];
    end
  end

  assign so_out = so_reg;
  assign so_oe_n_out = cs_s2_reg | cs_d_reg;

  // ==========================================================
  // Diagnosis latch
  // Set wins over clear so a fault during the closing edge is not lost
  logic diag_clear;
  assign diag_clear = cs_rise & frame_ok;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      diag_reg <= `PSSW_DIAG_RST;
    end else if (diag_clear) begin
      diag_reg <= fault_in;
    end else begin
      diag_reg <= diag_reg | fault_in;
    end
  end

  assign diag_out = diag_reg;

  // ==========================================================
  // Input matrix and command execution
  logic [7:0] matrix_reg;
  logic [1:0] channel_reg;
  logic sleep_reg, sense_en_reg, sense_sel_reg, sense_sum_reg;
  pssw_cmd_t cmd;
  logic [3:0] data;
  logic cmd_valid, exec;

  assign cmd = pssw_cmd_t'(shift_reg[`PSSW_CMD_MSB:`PSSW_CMD_LSB]);
  assign data = shift_reg[`PSSW_DATA_MSB:`PSSW_DATA_LSB];
  assign cmd_valid = (cmd == PSSW_CMD_NOP) || (cmd == PSSW_CMD_CHANNEL) || (cmd == PSSW_CMD_SENSE)
    || (cmd == PSSW_CMD_SLEEP) || (cmd == PSSW_CMD_WAKE);
  assign exec = cs_rise & frame_ok & cmd_valid;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      matrix_reg <= `PSSW_MATRIX_RST;
    end else if (exec && cmd == PSSW_CMD_SLEEP) begin
      matrix_reg <= `PSSW_MATRIX_RST;
    end else if (cs_rise && frame_ok) begin
      matrix_reg <= shift_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_reg <= `PSSW_CHANNEL_RST;
      sense_en_reg <= 1'b0;
      sense_sel_reg <= 1'b0;
      sense_sum_reg <= 1'b0;
    end else if (exec) begin
      case (cmd)
        PSSW_CMD_CHANNEL: begin
          channel_reg <= {data[`PSSW_CH1_BIT], data[`PSSW_CH0_BIT]};
        end
        PSSW_CMD_SENSE: begin
          sense_en_reg <= data[`PSSW_SENSE_EN_BIT];
          sense_sel_reg <= data[`PSSW_SENSE_SEL_BIT];
          sense_sum_reg <= data[`PSSW_SENSE_SUM_BIT];
        end
        PSSW_CMD_SLEEP: begin
          channel_reg <= `PSSW_CHANNEL_RST;
          sense_en_reg <= 1'b0;
          sense_sel_reg <= 1'b0;
          sense_sum_reg <= 1'b0;
        end
        default: begin
          channel_reg <= channel_reg;
        end
      endcase
    end
  end

  // Sleep holds channel outputs and current sense enable off until a wake command arrives
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sleep_reg <= 1'b0;
    end else if (exec && cmd == PSSW_CMD_SLEEP) begin
      sleep_reg <= 1'b1;
    end else if (exec && cmd == PSSW_CMD_WAKE) begin
      sleep_reg <= 1'b0;
    end
  end

  assign matrix_out = matrix_reg;
  assign channel_on_out = sleep_reg ? 2'h0 : channel_reg;
  assign sleep_out = sleep_reg;
  assign current_sense_enable_out = sense_en_reg & ~sleep_reg;
  assign current_sense_channel_out = sense_sel_reg;
  assign current_sense_sum_out = sense_sum_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Judged from the pin itself so that a broken synchroniser path is caught too
  property p_so_float;
    ($past(cs_n_in, 2) && $past(cs_n_in, 3)) |-> so_oe_n_out;
  endproperty
  a_so_float: assert property (p_so_float) else $error("Output driven while deselected");

  property p_load_diag;
    cs_fall |=> (shift_reg == $past(diag_reg)) && (so_out == $past(diag_reg[7]));
  endproperty
  a_load_diag: assert property (p_load_diag) else $error("Diagnosis not loaded at select fall");

  property p_commit;
    (cs_rise && frame_ok && !(cmd_valid && cmd == PSSW_CMD_SLEEP)) |=> matrix_reg == $past(shift_reg);
  endproperty
  a_commit: assert property (p_commit) else $error("Frame not committed to matrix");

  property p_clear;
    (cs_rise && frame_ok && fault_in == 8'h00) |=> diag_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("Diagnosis not cleared");

  property p_bad_frame;
    (cs_rise && !frame_ok) |=> $stable(matrix_reg) && $stable(channel_reg) && frame_error_out;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("Partial frame had effect");

  property p_shift_in;
    sclk_fall |=> shift_reg[0] == $past(si_s2_reg) && shift_reg[7:1] == $past(shift_reg[6:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Input bit not shifted");

  property p_ignore;
    (cs_s2_reg && cs_d_reg) |=> $stable(shift_reg) && $stable(bit_cnt_reg);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Activity accepted while deselected");

  property p_sleep;
    (exec && cmd == PSSW_CMD_SLEEP) |=> channel_reg == 2'h0 && !sense_en_reg && sleep_out ##1 channel_on_out == 2'h0;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep did not restore defaults");

  property p_invalid;
    (cs_rise && frame_ok && !cmd_valid) |=> $stable(channel_reg) && $stable(sense_en_reg) && $stable(sleep_reg);
  endproperty
  a_invalid: assert property (p_invalid) else $error("Invalid command executed");

  property p_launch;
    sclk_rise |=> so_out == $past(shift_reg[7]);
  endproperty
  a_launch: assert property (p_launch) else $error("Output bit not launched");

endmodule

/* sim/pssw_spi_master.sv */
// Purpose: Host-side serial master model for the power switch slave
// Assumes: 40 MHz clk_in; serial clock of 200 ns, 100 ns per half
// Notes: Up to 16 bits per access, so short and chained frames can be made
`timescale 1ns/1ps
module pssw_spi_master (
  input wire logic clk_in,
  input wire logic so_in,
  input wire logic so_oe_n_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out
);
  // ==========================================================
  // Idle levels follow the pin pulls: select up, clock and data down
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // ==========================================================
  // One access, MSB first; a floating output is read as unknown
  task automatic xfer(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    wait_clk(1);
    cs_n_out = 1'b0;
    wait_clk(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      si_out = tx[i];
      sclk_out = 1'b1;
      wait_clk(4);
      sclk_out = 1'b0;
      wait_clk(4);
      rx = {rx[14:0], so_oe_n_in ? 1'bx : so_in};
    end
    si_out = 1'b0;
    wait_clk(4);
    cs_n_out = 1'b1;
    wait_clk(14);
  endtask

  // ==========================================================
  // Clock and data activity while deselected
  task automatic noise(input int n);
    repeat (n) begin
      si_out = ~si_out;
      sclk_out = 1'b1;
      wait_clk(4);
      sclk_out = 1'b0;
      wait_clk(4);
    end
    si_out = 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
// Purpose: Self-checking bench for the power switch serial slave
// Assumes: Master model drives the serial pins, bench drives faults
// Notes: Expected values come from the frame layout and command codes
`timescale 1ns/1ps
module testbench
  import pssw_pkg::*;
;
  logic clk_in, rst_in, cs_n, sclk, si, so, so_oe_n, sleep, cs_en, cs_ch, cs_sum, frame_err;
  logic [7:0] fault, diag, matrix;
  logic [1:0] channel_on;
  logic [15:0] rx;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  pssw_spi_slave i_pssw_spi_slave (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
    .so_out(so), .so_oe_n_out(so_oe_n), .fault_in(fault), .diag_out(diag),
    .matrix_out(matrix), .channel_on_out(channel_on), .sleep_out(sleep),
    .current_sense_enable_out(cs_en), .current_sense_channel_out(cs_ch),
    .current_sense_sum_out(cs_sum), .frame_error_out(frame_err)
  );

  pssw_spi_master i_pssw_spi_master (
    .clk_in(clk_in), .so_in(so), .so_oe_n_in(so_oe_n),
    .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si)
  );

  // ==========================================================
  // Clock, timeout and reporting
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fr(input int n, input logic [15:0] tx);
    i_pssw_spi_master.xfer(n, tx, rx);
  endtask

  // Faults are events: one cycle is enough to latch
  task automatic pulse(input logic [7:0] v);
    @(negedge clk_in) fault = v;
    @(negedge clk_in) fault = 8'h00;
    repeat (2) @(negedge clk_in);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    int lens[4];
    lens = '{0, 7, 9, 12};
    rst_in = 1'b1;
    fault = 8'h00;
    repeat (10) @(negedge clk_in);
    rst_in = 1'b0;
    chk(so_oe_n, 1'b1);
    chk({matrix, diag}, 16'h0000);
    chk({channel_on, sleep, cs_en, cs_ch, cs_sum, frame_err}, 16'h0000);
    pulse(8'ha5);
    chk(diag, 8'ha5);
    fr(8, {PSSW_CMD_CHANNEL, 4'h3});
    chk(rx, 16'h00a5);
    chk(matrix, 8'h13);
    chk(channel_on, 2'h3);
    chk(diag, 8'h00);
    fr(8, {PSSW_CMD_SENSE, 4'h7});
    chk({cs_en, cs_ch, cs_sum}, 3'h7);
    fr(8, {PSSW_CMD_SENSE, 4'h1});
    chk({cs_en, cs_ch, cs_sum}, 3'h4);
    fr(8, 16'h00f2);
    chk({matrix, channel_on, cs_en, cs_ch, cs_sum}, 16'h1e5c);
    pulse(8'h0f);
    foreach (lens[k]) begin
      fr(lens[k], 16'h0010);
      chk({frame_err, matrix, diag}, 24'h01f20f);
    end
    fr(16, {8'h5a, PSSW_CMD_CHANNEL, 4'h2});
    chk(rx, 16'h0f5a);
    chk({frame_err, channel_on, diag}, 16'h0200);
    i_pssw_spi_master.noise(16);
    chk({so_oe_n, frame_err, matrix}, 16'h0212);
    fr(8, {PSSW_CMD_SLEEP, 4'h0});
    chk({sleep, matrix, channel_on, cs_en, cs_ch, cs_sum}, 16'h2000);
    fr(8, {PSSW_CMD_WAKE, 4'h0});
    chk({sleep, matrix, channel_on}, 16'h0100);
    fr(8, {PSSW_CMD_NOP, 4'h3});
    chk({sleep, matrix, channel_on, cs_en}, 16'h0018);
    tally_and_finish();
  end
endmodule
